// ---- irq_nest_pkg.sv ----
// Purpose: Constants for the fast-interrupt nesting and external trigger block
// Assumes: AHB-Lite register bus, 32-bit words, full 32-bit address decode
// Notes: Source order follows the trigger field order in the trigger register
package irq_nest_pkg;
	localparam int SRC_COUNT = 6;
	localparam int PRIO_W = 3;
	localparam int NEST_W = 8;
	localparam int TRIG_W = 2;
	localparam int PRIO_STRIDE = 4;
	localparam int VEC_LSB = 2;
	localparam int VEC_W = 5;

	// Register byte addresses
	localparam logic [31:0] NESTING_CONTROL_ADDR = 32'hffff0030;
	localparam logic [31:0] EXT_TRIGGER_CONFIG_ADDR = 32'hffff0034;
	localparam logic [31:0] EDGE_REQUEST_CLEAR_ADDR = 32'hffff0038;
	localparam logic [31:0] FAST_VECTOR_ADDR = 32'hffff011c;
	localparam logic [31:0] FAST_NEST_STATUS_ADDR = 32'hffff013c;
	localparam logic [31:0] FAST_ENABLE_ADDR = 32'hffff0200;
	localparam logic [31:0] NORMAL_ENABLE_ADDR = 32'hffff0204;
	localparam logic [31:0] SOURCE_PRIORITY_ADDR = 32'hffff0208;
	localparam logic [31:0] EVENT_STATUS_ADDR = 32'hffff020c;
	localparam logic [31:0] EVENT_ENABLE_ADDR = 32'hffff0210;
	localparam logic [31:0] EVENT_CLEAR_ADDR = 32'hffff0214;

	// Nesting control bits
	localparam int NORMAL_NEST_ENABLE_BIT = 0;
	localparam int FAST_NEST_ENABLE_BIT = 1;
	localparam int NEST_CTRL_W = 2;

	// Trigger field width in the config register is TRIG_W * SRC_COUNT
	localparam int TRIG_CFG_W = 12;
	localparam logic [1:0] TRIG_LEVEL_HIGH = 2'h0;
	localparam logic [1:0] TRIG_LEVEL_LOW = 2'h1;
	localparam logic [1:0] TRIG_RISING = 2'h2;
	localparam logic [1:0] TRIG_FALLING = 2'h3;

	// Edge clear bit per source: ext0, ext1, logic0, ext2, ext3, logic1
	localparam int CLEAR_BIT [SRC_COUNT] = '{13, 16, 17, 18, 19, 20};

	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ---- irq_nest_status_ext_trigger.sv ----
// Purpose: Fast-interrupt nesting status, external/logic-array trigger setup and edge clear
// Assumes: Single clock, synchronous active-high reset, one AHB-Lite master
// Notes: Priority 0 is the highest; source index order ext0, ext1, logic0, ext2, ext3, logic1
// Notes on behaviour
// RL1: With fast nesting on, reading the fast vector sets the status bit numbered by the active source's priority.
// RL2: A set status bit blocks every fast interrupt of that priority or a lower one.
// RL3: A write to the fast nesting status clears only its highest-priority (lowest-numbered) set bit.
// RL4: Software clears status bits in priority order, since the device only removes the top one.
// RL5: The status holds bits 7 to 0; bits 31 to 8 read as zero and are not written by software.
// RL6: Four external pins and two logic-array sources, each set as level, rising or falling triggered.
// RL7: A source raises a request only while its fast or normal enable bit is set.
// RL8: Trigger code 11 is falling edge, 10 rising edge, 01 low level and 00 high level.
// RL9: Trigger fields sit at 1:0, 3:2, 5:4, 7:6, 9:8 and 11:10 in source order; upper bits are reserved.
// RL10: An edge request stays latched until a one is written to its clear bit 13, 16, 17, 18, 19 or 20.
// RL11: The service routine of an edge source writes a one to its clear bit.
// RL12: Software leaves the reserved bits of the edge clear register unwritten.
// RL13: Control bit 1 enables fast nesting, bit 0 normal nesting (here bit 0 is stored and read back but has no effect); fast always outranks normal.
// RL14: Each source has a 3-bit priority that picks the status bit set when it is serviced.
// RL15: External pins pass a two-flop synchroniser; writing zero to a clear bit does nothing.
// RL16: Level sources are not latched and follow the synchronised level.
`timescale 1ns/100ps
`default_nettype none
module irq_nest_status_ext_trigger #(
	parameter int SRC_N = irq_nest_pkg::SRC_COUNT
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [3:0] extPin,
	input wire logic [1:0] logicIrq,
	output logic fastIrq,
	output logic normalIrq,
	output logic eventIrq
);
	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} bus_state_t;

	bus_state_t busState_q, busState_d;
	logic [31:0] busAddr_q, busAddr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic [1:0] nestCtrl_q, nestCtrl_d;
	logic [11:0] trigCfg_q, trigCfg_d;
	logic [7:0] fastNest_q, fastNest_d;
	logic [SRC_N-1:0] fastEn_q, fastEn_d;
	logic [SRC_N-1:0] normalEn_q, normalEn_d;
	logic [31:0] srcPrio_q, srcPrio_d;
	logic [SRC_N-1:0] evtStatus_q, evtStatus_d;
	logic [SRC_N-1:0] evtEnable_q, evtEnable_d;
	logic [3:0] pinMeta_q, pinSync_q;
	logic [SRC_N-1:0] srcPrev_q, edgeLatch_q, edgeLatch_d, reqPrev_q;
	logic fastIrq_q, fastIrq_d, normalIrq_q, normalIrq_d, eventIrq_q, eventIrq_d;

	logic addrTake, wrActive, rdFinish;
	logic fastNestEnable;
	logic [SRC_N-1:0] srcLevel, edgeEvt, levelActive, edgeMode, clearHit, srcRequest, fastCand;
	logic [SRC_N-1:0] enabledReq;
	logic candValid;
	logic [2:0] candPrio;
	logic [4:0] candIdx;
	logic [31:0] edgeReadWord, readWord;

	assign fastNestEnable = nestCtrl_q[irq_nest_pkg::FAST_NEST_ENABLE_BIT]; // [RL13]
	assign srcLevel = {logicIrq[1], pinSync_q[3], pinSync_q[2], logicIrq[0], pinSync_q[1], pinSync_q[0]};
	assign addrTake = hsel && hready && htrans == irq_nest_pkg::HTRANS_NONSEQ;
	assign wrActive = busState_q == BUS_WRITE;
	assign rdFinish = busState_q == BUS_READ_WAIT;

	// True when no status bit at this priority or above it is set
	function automatic logic notBlocked(input logic [7:0] status, input logic [2:0] prio);
		logic ok;
		ok = 1'b1;
		for (int k = 0; k < irq_nest_pkg::NEST_W; k++) begin
			if (k <= int'(prio) && status[k]) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	// Per-source trigger decode, edge latch and request
	genvar gi;
	generate
		for (gi = 0; gi < SRC_N; gi++) begin : g_src
			logic [1:0] mode;
			assign mode = trigCfg_q[gi*irq_nest_pkg::TRIG_W +: irq_nest_pkg::TRIG_W]; // [RL9]
			assign edgeMode[gi] = mode == irq_nest_pkg::TRIG_RISING || mode == irq_nest_pkg::TRIG_FALLING;
			assign edgeEvt[gi] = (mode == irq_nest_pkg::TRIG_RISING && srcLevel[gi] && !srcPrev_q[gi])
				|| (mode == irq_nest_pkg::TRIG_FALLING && !srcLevel[gi] && srcPrev_q[gi]); // [RL8] [RL6]
			assign levelActive[gi] = (mode == irq_nest_pkg::TRIG_LEVEL_HIGH && srcLevel[gi])
				|| (mode == irq_nest_pkg::TRIG_LEVEL_LOW && !srcLevel[gi]); // [RL8] [RL16]
			// A clear needs a one in the source's own bit; zeros leave the latch alone
			assign clearHit[gi] = wrActive && busAddr_q == irq_nest_pkg::EDGE_REQUEST_CLEAR_ADDR
				&& hwdata[irq_nest_pkg::CLEAR_BIT[gi]]; // [RL15]
			// Set wins over a clear in the same cycle
			assign edgeLatch_d[gi] = edgeEvt[gi] || (edgeLatch_q[gi] && !clearHit[gi]); // [RL10]
			assign srcRequest[gi] = edgeMode[gi] ? edgeLatch_q[gi] : levelActive[gi]; // [RL16]
			assign enabledReq[gi] = srcRequest[gi] && (fastEn_q[gi] || normalEn_q[gi]); // [RL7]
			assign fastCand[gi] = srcRequest[gi] && fastEn_q[gi] && (!fastNestEnable
				|| notBlocked(fastNest_q, srcPrio_q[gi*irq_nest_pkg::PRIO_STRIDE +: irq_nest_pkg::PRIO_W])); // [RL2]

			edge_hold_a: assert property (@(posedge clock) disable iff (reset) // [RL10]
				edgeLatch_q[gi] && !clearHit[gi] |=> edgeLatch_q[gi])
				else $error("edge request dropped without a clear");

			edge_set_a: assert property (@(posedge clock) disable iff (reset) // [RL10]
				edgeEvt[gi] |=> edgeLatch_q[gi])
				else $error("edge event not latched");

			clear_drop_a: assert property (@(posedge clock) disable iff (reset) // [RL10]
				clearHit[gi] && !edgeEvt[gi] |=> !edgeLatch_q[gi])
				else $error("edge request kept after a clear");
		end
	endgenerate

	// Latched edge requests read back at their clear bit positions
	always_comb begin
		edgeReadWord = irq_nest_pkg::RESET_WORD;
		for (int i = 0; i < SRC_N; i++) begin
			edgeReadWord[irq_nest_pkg::CLEAR_BIT[i]] = edgeLatch_q[i]; // [RL10]
		end
	end

	// Fast source to service: highest-priority unblocked one with fast nesting on, lowest index with it off; ties go to the lower index
	always_comb begin
		candValid = 1'b0;
		candPrio = '0;
		candIdx = '0;
		for (int i = 0; i < SRC_N; i++) begin
			if (fastCand[i] && (!candValid || (fastNestEnable
				&& srcPrio_q[i*irq_nest_pkg::PRIO_STRIDE +: irq_nest_pkg::PRIO_W] < candPrio))) begin // [RL14]
				candValid = 1'b1;
				candPrio = srcPrio_q[i*irq_nest_pkg::PRIO_STRIDE +: irq_nest_pkg::PRIO_W];
				candIdx = 5'(i);
			end
		end
	end

	// Synchroniser and source history
	always_ff @(posedge clock) begin
		if (reset) begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
			srcPrev_q <= '0;
			edgeLatch_q <= '0;
			reqPrev_q <= '0;
		end else begin
			pinMeta_q <= extPin; // [RL15]
			pinSync_q <= pinMeta_q; // [RL15]
			srcPrev_q <= srcLevel;
			edgeLatch_q <= edgeLatch_d;
			reqPrev_q <= srcRequest;
		end
	end

	// Reset clears both stages, so the check starts two edges after it
	sync_depth_a: assert property (@(posedge clock) disable iff (reset) // [RL15]
		!$past(reset, 2) |-> pinSync_q == $past(extPin, 2))
		else $error("pin reached detection without two synchroniser stages");

	// Bus sequencing: writes take no wait, reads take one wait state
	always_comb begin
		busState_d = busState_q;
		busAddr_d = busAddr_q;
		if (busState_q == BUS_READ_WAIT) begin
			busState_d = BUS_READ_DONE;
		end else if (addrTake) begin
			busAddr_d = haddr;
			busState_d = hwrite ? BUS_WRITE : BUS_READ_WAIT;
		end else begin
			busState_d = BUS_IDLE;
		end
	end

	assign hreadyout = busState_q != BUS_READ_WAIT;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// Read mux
	always_comb begin
		readWord = irq_nest_pkg::RESET_WORD;
		if (busAddr_q == irq_nest_pkg::NESTING_CONTROL_ADDR) begin
			readWord = 32'(nestCtrl_q);
		end else if (busAddr_q == irq_nest_pkg::EXT_TRIGGER_CONFIG_ADDR) begin
			readWord = 32'(trigCfg_q);
		end else if (busAddr_q == irq_nest_pkg::EDGE_REQUEST_CLEAR_ADDR) begin
			readWord = edgeReadWord;
		end else if (busAddr_q == irq_nest_pkg::FAST_VECTOR_ADDR) begin
			readWord = candValid ? 32'({candIdx, 2'h0}) : irq_nest_pkg::RESET_WORD;
		end else if (busAddr_q == irq_nest_pkg::FAST_NEST_STATUS_ADDR) begin
			readWord = 32'(fastNest_q); // [RL5]
		end else if (busAddr_q == irq_nest_pkg::FAST_ENABLE_ADDR) begin
			readWord = 32'(fastEn_q);
		end else if (busAddr_q == irq_nest_pkg::NORMAL_ENABLE_ADDR) begin
			readWord = 32'(normalEn_q);
		end else if (busAddr_q == irq_nest_pkg::SOURCE_PRIORITY_ADDR) begin
			readWord = srcPrio_q;
		end else if (busAddr_q == irq_nest_pkg::EVENT_STATUS_ADDR) begin
			readWord = 32'(evtStatus_q);
		end else if (busAddr_q == irq_nest_pkg::EVENT_ENABLE_ADDR) begin
			readWord = 32'(evtEnable_q);
		end
	end

	// Register file next values
	always_comb begin
		nestCtrl_d = nestCtrl_q;
		trigCfg_d = trigCfg_q;
		fastNest_d = fastNest_q;
		fastEn_d = fastEn_q;
		normalEn_d = normalEn_q;
		srcPrio_d = srcPrio_q;
		evtEnable_d = evtEnable_q;
		hrdata_d = rdFinish ? readWord : hrdata_q;
		// New events win over a clear in the same cycle
		evtStatus_d = evtStatus_q | (srcRequest & ~reqPrev_q);
		if (wrActive) begin
			if (busAddr_q == irq_nest_pkg::NESTING_CONTROL_ADDR) begin
				nestCtrl_d = hwdata[irq_nest_pkg::NEST_CTRL_W-1:0];
			end else if (busAddr_q == irq_nest_pkg::EXT_TRIGGER_CONFIG_ADDR) begin
				trigCfg_d = hwdata[irq_nest_pkg::TRIG_CFG_W-1:0]; // [RL9]
			end else if (busAddr_q == irq_nest_pkg::FAST_NEST_STATUS_ADDR) begin
				fastNest_d = fastNest_q & (fastNest_q - 8'h01); // [RL3]
			end else if (busAddr_q == irq_nest_pkg::FAST_ENABLE_ADDR) begin
				fastEn_d = hwdata[SRC_N-1:0];
			end else if (busAddr_q == irq_nest_pkg::NORMAL_ENABLE_ADDR) begin
				normalEn_d = hwdata[SRC_N-1:0];
			end else if (busAddr_q == irq_nest_pkg::SOURCE_PRIORITY_ADDR) begin
				srcPrio_d = hwdata;
			end else if (busAddr_q == irq_nest_pkg::EVENT_ENABLE_ADDR) begin
				evtEnable_d = hwdata[SRC_N-1:0];
			end else if (busAddr_q == irq_nest_pkg::EVENT_CLEAR_ADDR) begin
				evtStatus_d = (evtStatus_q & ~hwdata[SRC_N-1:0]) | (srcRequest & ~reqPrev_q);
			end
		end
		// With fast nesting on, a servicing read of the fast vector marks its priority as in progress
		if (rdFinish && busAddr_q == irq_nest_pkg::FAST_VECTOR_ADDR && fastNestEnable && candValid) begin
			fastNest_d = fastNest_q | (8'h01 << candPrio); // [RL1] [RL14]
		end
	end

	// Outputs: fast always outranks normal
	always_comb begin
		fastIrq_d = candValid;
		normalIrq_d = !candValid && |(srcRequest & normalEn_q); // [RL13] [RL7]
		eventIrq_d = |(evtStatus_q & evtEnable_q);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			busState_q <= BUS_IDLE;
			busAddr_q <= irq_nest_pkg::RESET_WORD;
			hrdata_q <= irq_nest_pkg::RESET_WORD;
			nestCtrl_q <= '0;
			trigCfg_q <= '0;
			fastNest_q <= '0;
			fastEn_q <= '0;
			normalEn_q <= '0;
			srcPrio_q <= irq_nest_pkg::RESET_WORD;
			evtStatus_q <= '0;
			evtEnable_q <= '0;
			fastIrq_q <= 1'b0;
			normalIrq_q <= 1'b0;
			eventIrq_q <= 1'b0;
		end else begin
			busState_q <= busState_d;
			busAddr_q <= busAddr_d;
			hrdata_q <= hrdata_d;
			nestCtrl_q <= nestCtrl_d;
			trigCfg_q <= trigCfg_d;
			fastNest_q <= fastNest_d;
			fastEn_q <= fastEn_d;
			normalEn_q <= normalEn_d;
			srcPrio_q <= srcPrio_d;
			evtStatus_q <= evtStatus_d;
			evtEnable_q <= evtEnable_d;
			fastIrq_q <= fastIrq_d;
			normalIrq_q <= normalIrq_d;
			eventIrq_q <= eventIrq_d;
		end
	end

	assign fastIrq = fastIrq_q;
	assign normalIrq = normalIrq_q;
	assign eventIrq = eventIrq_q;

	// Status, trigger and request checks
	status_set_a: assert property (@(posedge clock) disable iff (reset) // [RL1]
		rdFinish && busAddr_q == irq_nest_pkg::FAST_VECTOR_ADDR && fastNestEnable && candValid
		|=> fastNest_q[$past(candPrio)])
		else $error("fast vector read did not set its status bit");

	status_hold_a: assert property (@(posedge clock) disable iff (reset) // [RL1]
		rdFinish && busAddr_q == irq_nest_pkg::FAST_VECTOR_ADDR && !fastNestEnable
		|=> fastNest_q == $past(fastNest_q))
		else $error("fast vector read changed the status with nesting off");

	clear_one_a: assert property (@(posedge clock) disable iff (reset) // [RL3]
		wrActive && busAddr_q == irq_nest_pkg::FAST_NEST_STATUS_ADDR
		|=> fastNest_q == ($past(fastNest_q) & ($past(fastNest_q) - 8'h01)))
		else $error("status write did not clear exactly the top bit");

	nest_block_a: assert property (@(posedge clock) disable iff (reset) // [RL2]
		fastNestEnable && fastNest_q[0] |=> !fastIrq_q)
		else $error("fast interrupt passed a priority 0 block");

	status_upper_a: assert property (@(posedge clock) disable iff (reset) // [RL5]
		busState_q == BUS_READ_DONE && busAddr_q == irq_nest_pkg::FAST_NEST_STATUS_ADDR
		|-> hrdata[31:8] == 24'h000000)
		else $error("reserved status bits read nonzero");

	level_follow_a: assert property (@(posedge clock) disable iff (reset) // [RL16]
		trigCfg_q[1:0] == irq_nest_pkg::TRIG_LEVEL_HIGH && $past(trigCfg_q[1:0]) == irq_nest_pkg::TRIG_LEVEL_HIGH
		&& !$past(reset, 2) |-> srcRequest[0] == $past(extPin[0], 2))
		else $error("level request does not follow the synchronised pin");

	level_low_a: assert property (@(posedge clock) disable iff (reset) // [RL8]
		trigCfg_q[1:0] == irq_nest_pkg::TRIG_LEVEL_LOW && !$past(reset, 2)
		|-> srcRequest[0] == !$past(extPin[0], 2))
		else $error("low-level request does not follow the inverted pin");

	enable_gate_a: assert property (@(posedge clock) disable iff (reset) // [RL7]
		fastIrq_q || normalIrq_q |-> $past(|enabledReq))
		else $error("request raised without an enable bit");

	fast_first_a: assert property (@(posedge clock) disable iff (reset) // [RL13]
		fastIrq_q |-> !normalIrq_q)
		else $error("normal interrupt raised alongside a fast one");

	zero_clear_a: assert property (@(posedge clock) disable iff (reset) // [RL15]
		wrActive && busAddr_q == irq_nest_pkg::EDGE_REQUEST_CLEAR_ADDR && hwdata == 32'h00000000
		|=> edgeLatch_q == ($past(edgeLatch_q) | $past(edgeEvt)))
		else $error("writing zero to the clear register changed a latch");
endmodule
`default_nettype wire

// ---- pin_source_model.sv ----
// Purpose: Far-side model driving the external pins and logic-array request lines
// Assumes: Bench sets one level per source in source index order
// Notes: Logic-array lines are registered so they stay synchronous to clock
`timescale 1ns/100ps
`default_nettype none
module pin_source_model (
	input wire logic clock,
	input wire logic [5:0] srcLevel,
	output logic [3:0] extPin,
	output logic [1:0] logicIrq
);
	// Four pins and two logic-array sources in index order ext0, ext1, logic0, ext2, ext3, logic1
	always_ff @(posedge clock) begin
		extPin <= {srcLevel[4], srcLevel[3], srcLevel[1], srcLevel[0]};
		logicIrq <= {srcLevel[5], srcLevel[2]};
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for nesting status, trigger setup and edge clear
// Assumes: Single AHB-Lite master, hready looped from hreadyout
// Notes: Tests are sequences of register accesses and pin changes
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, fastIrq, normalIrq, eventIrq;
	logic [31:0] hrdata;
	logic [3:0] extPin;
	logic [1:0] logicIrq;
	logic [5:0] srcLevel = 6'h0;
	logic [1:0] code;
	int n_fail = 0;
	int n_compared = 0;
	int cyc = 0;

	always #4 clock = ~clock;

	irq_nest_status_ext_trigger i_dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .extPin(extPin), .logicIrq(logicIrq),
		.fastIrq(fastIrq), .normalIrq(normalIrq), .eventIrq(eventIrq));
	pin_source_model i_pins (.clock(clock), .srcLevel(srcLevel), .extPin(extPin), .logicIrq(logicIrq));

	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// One single-word transfer: address phase, then data phase, each held until hready
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= irq_nest_pkg::HTRANS_NONSEQ;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		r = hrdata;
		check({31'h0, hresp}, 32'h0, "response");
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask

	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0, r);
		check(r, exp, msg);
	endtask

	task automatic settle();
		repeat (6) @(posedge clock);
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			$display("MISMATCH at %0t: run did not finish", $time);
			results();
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rdchk(irq_nest_pkg::EXT_TRIGGER_CONFIG_ADDR, 32'h0, "trigger reset");
		rdchk(irq_nest_pkg::EDGE_REQUEST_CLEAR_ADDR, 32'h0, "clear reset");
		rdchk(irq_nest_pkg::FAST_NEST_STATUS_ADDR, 32'h0, "status reset");
		rdchk(32'hffff0100, 32'h0, "unmapped read");
		wr(irq_nest_pkg::EXT_TRIGGER_CONFIG_ADDR, 32'hffffffff);
		rdchk(irq_nest_pkg::EXT_TRIGGER_CONFIG_ADDR, 32'h00000fff, "trigger fields");
		wr(irq_nest_pkg::EXT_TRIGGER_CONFIG_ADDR, 32'h0);
		$display("test reset and fields done");

		// Nesting: priority 3 source then priority 0 source gives status 0x09
		srcLevel <= 6'h09;
		wr(irq_nest_pkg::NESTING_CONTROL_ADDR, 32'h2);
		wr(irq_nest_pkg::SOURCE_PRIORITY_ADDR, 32'h00003000);
		wr(irq_nest_pkg::FAST_ENABLE_ADDR, 32'h08);
		settle();
		check({31'h0, fastIrq}, 32'h1, "fast before vector");
		rdchk(irq_nest_pkg::FAST_VECTOR_ADDR, 32'h0000000c, "vector src3");
		rdchk(irq_nest_pkg::FAST_NEST_STATUS_ADDR, 32'h08, "status prio3");
		settle();
		check({31'h0, fastIrq}, 32'h0, "prio3 blocked");
		wr(irq_nest_pkg::FAST_ENABLE_ADDR, 32'h09);
		settle();
		check({31'h0, fastIrq}, 32'h1, "prio0 not blocked");
		rdchk(irq_nest_pkg::FAST_VECTOR_ADDR, 32'h0, "vector src0");
		rdchk(irq_nest_pkg::FAST_NEST_STATUS_ADDR, 32'h09, "status 09");
		wr(irq_nest_pkg::FAST_NEST_STATUS_ADDR, 32'h000000ff);
		rdchk(irq_nest_pkg::FAST_NEST_STATUS_ADDR, 32'h08, "first clear");
		wr(irq_nest_pkg::FAST_NEST_STATUS_ADDR, 32'h000000ff);
		rdchk(irq_nest_pkg::FAST_NEST_STATUS_ADDR, 32'h0, "second clear");
		wr(irq_nest_pkg::FAST_ENABLE_ADDR, 32'h0);
		wr(irq_nest_pkg::NESTING_CONTROL_ADDR, 32'h0);
		settle();
		check({30'h0, normalIrq, fastIrq}, 32'h0, "disabled source silent");
		srcLevel <= 6'h0;
		$display("test nesting done");

		// Level modes on ext0
		wr(irq_nest_pkg::FAST_ENABLE_ADDR, 32'h01);
		for (int m = 0; m < 2; m++) begin
			code = m[1:0];
			wr(irq_nest_pkg::EXT_TRIGGER_CONFIG_ADDR, {30'h0, code});
			srcLevel[0] <= (code == irq_nest_pkg::TRIG_LEVEL_HIGH);
			settle();
			check({31'h0, fastIrq}, 32'h1, "level active");
			srcLevel[0] <= (code != irq_nest_pkg::TRIG_LEVEL_HIGH);
			settle();
			check({31'h0, fastIrq}, 32'h0, "level released");
		end
		wr(irq_nest_pkg::FAST_ENABLE_ADDR, 32'h0);
		$display("test level modes done");

		// Edge modes on every source, odd sources through the normal enable
		for (int i = 0; i < irq_nest_pkg::SRC_COUNT; i++) begin
			code = (i % 2) ? irq_nest_pkg::TRIG_FALLING : irq_nest_pkg::TRIG_RISING;
			srcLevel[i] <= (code == irq_nest_pkg::TRIG_FALLING);
			wr(irq_nest_pkg::EXT_TRIGGER_CONFIG_ADDR, 32'(code) << (2 * i));
			settle();
			wr(irq_nest_pkg::EDGE_REQUEST_CLEAR_ADDR, 32'h1 << irq_nest_pkg::CLEAR_BIT[i]);
			wr((i % 2) ? irq_nest_pkg::NORMAL_ENABLE_ADDR : irq_nest_pkg::FAST_ENABLE_ADDR, 32'h1 << i);
			srcLevel[i] <= ~srcLevel[i];
			repeat (2) @(posedge clock);
			srcLevel[i] <= ~srcLevel[i];
			settle();
			check({31'h0, (i % 2) ? normalIrq : fastIrq}, 32'h1, "edge latched");
			rdchk(irq_nest_pkg::FAST_VECTOR_ADDR, (i % 2) ? 32'h0 : 32'(4 * i), "vector without nesting");
			rdchk(irq_nest_pkg::EDGE_REQUEST_CLEAR_ADDR, 32'h1 << irq_nest_pkg::CLEAR_BIT[i], "latch bit");
			wr(irq_nest_pkg::EDGE_REQUEST_CLEAR_ADDR, 32'h0);
			settle();
			check({31'h0, (i % 2) ? normalIrq : fastIrq}, 32'h1, "zero write kept");
			wr(irq_nest_pkg::EDGE_REQUEST_CLEAR_ADDR, 32'h1 << irq_nest_pkg::CLEAR_BIT[i]);
			settle();
			check({30'h0, normalIrq, fastIrq}, 32'h0, "edge cleared");
			wr((i % 2) ? irq_nest_pkg::NORMAL_ENABLE_ADDR : irq_nest_pkg::FAST_ENABLE_ADDR, 32'h0);
		end
		$display("test edge modes done");

		// Event status: sticky on each rising request, cleared by writing ones
		wr(irq_nest_pkg::EVENT_CLEAR_ADDR, 32'h3f);
		wr(irq_nest_pkg::EVENT_ENABLE_ADDR, 32'h3f);
		settle();
		rdchk(irq_nest_pkg::EVENT_STATUS_ADDR, 32'h0, "events cleared");
		check({31'h0, eventIrq}, 32'h0, "event idle");
		srcLevel[0] <= 1'b1;
		settle();
		check({31'h0, eventIrq}, 32'h1, "event raised");
		rdchk(irq_nest_pkg::EVENT_STATUS_ADDR, 32'h01, "event bit");
		srcLevel[0] <= 1'b0;
		settle();
		rdchk(irq_nest_pkg::EVENT_STATUS_ADDR, 32'h01, "event sticky");
		wr(irq_nest_pkg::EVENT_CLEAR_ADDR, 32'h01);
		settle();
		check({31'h0, eventIrq}, 32'h0, "event cleared");
		rdchk(irq_nest_pkg::EVENT_STATUS_ADDR, 32'h0, "event status empty");
		$display("test events done");
		results();
	end
endmodule
`default_nettype wire
